// ### switch_pkg.sv
// shared constants, register map and carrier types of the switch engine
package switch_pkg;
  // port and table geometry
  localparam int NPORTS      = 3;
  localparam int PORT_W      = 2;
  localparam int TBL_ENTRIES = 1024;
  localparam int IDX_W       = 10;
  // shared frame buffer pool
  localparam int BUF_COUNT   = 256;
  localparam int BUF_BYTES   = 128;
  localparam int POOL_BYTES  = BUF_COUNT * BUF_BYTES;
  localparam int PTR_W       = 15;
  localparam int BUF_LSB     = 7;
  // legal frame sizes in bytes
  localparam int MIN_LEN     = 64;
  localparam int MAX_LEN     = 1536;
  localparam int LEN_W       = 11;
  localparam int DA_END      = 6;
  localparam int SA_END      = 12;
  localparam int TYPE_END    = 14;
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  // mac timing, times in ns and bit times
  localparam int CLK_NS      = 100;
  localparam int BIT_NS      = 100;
  localparam int IPG_BITS    = 96;
  localparam int SLOT_BITS   = 512;
  localparam int IPG_CYC  = (IPG_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOT_CYC = (SLOT_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LATE_BYTES  = SLOT_BITS / 8;
  localparam int MAX_COLL    = 16;
  localparam int BACKOFF_MAX = 10;
  localparam int AGGR_MAX    = 2;
  localparam int WAIT_W      = 20;
  // aging
  localparam int CLK_HZ      = 10_000_000;
  localparam int AGE_S       = 200;
  // apb register offsets
  localparam logic [11:0] OFS_GSC1 = 12'h000;
  localparam logic [11:0] OFS_MODE = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_DROP = 12'h00c;
  // field positions
  localparam int GSC1_RETRY  = 8;
  localparam int GSC1_AGE    = 10;
  localparam int MODE_FILT   = 0;
  localparam int MODE_AGGR   = 1;
  localparam int MODE_HALF   = 2;
  localparam int MODE_FWD    = 8;
  localparam int STAT_BUF    = 16;
  // reset values
  localparam logic [31:0] GSC1_RST = 32'h0000_0400;
  localparam logic [31:0] MODE_RST = 32'h0000_0700;

  typedef struct packed {
    logic              vld;
    logic [47:0]       mac;
    logic [PORT_W-1:0] port;
    logic [7:0]        ts;
  } entry_t;

  typedef struct packed {
    logic [PTR_W-1:0]  start;
    logic [LEN_W-1:0]  len;
    logic [NPORTS-1:0] ports;
  } desc_t;
endpackage

// ### tx_timing.sv
// transmit gap, collision back-off and drop decisions for one egress
`timescale 1ns/1ps
module tx_timing import switch_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // configuration
  input  wire logic half,
  input  wire logic aggr,
  input  wire logic retry_excess,
  // frame events from the egress engine
  input  wire logic start,
  input  wire logic beat,
  input  wire logic done,
  input  wire logic col,
  input  wire logic crs,
  // decisions
  output logic      go,
  output logic      retry,
  output logic      drop
);
  logic [WAIT_W-1:0] wait_q, wait_d, boff_q, boff_d;
  logic [4:0]        ncol_q, ncol_d;
  logic [6:0]        bytes_q, bytes_d;
  logic              hold_q, hold_d, retry_q, retry_d, drop_q, drop_d;
  logic [9:0]        lfsr_q, lfsr_d;
  logic [3:0]        lim;
  logic [9:0]        slots;

  assign go    = wait_q == '0 && !hold_q && !(half && crs);
  assign retry = retry_q;
  assign drop  = drop_q;

  // next values of gap, back-off and collision bookkeeping
  always_comb begin
    wait_d  = (wait_q != '0) ? wait_q - 1'b1 : wait_q;
    boff_d  = boff_q;
    ncol_d  = ncol_q;
    hold_d  = hold_q;
    retry_d = 1'b0;
    drop_d  = 1'b0;
    bytes_d = bytes_q;
    lfsr_d  = {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
    lim     = (ncol_q >= 5'(BACKOFF_MAX)) ? 4'(BACKOFF_MAX)
                                          : 4'(ncol_q + 1'b1);
    if (aggr && lim > 4'(AGGR_MAX))
      lim = 4'(AGGR_MAX);
    slots   = lfsr_q & 10'((11'(1) << lim) - 11'(1));
    if (start)
      bytes_d = '0;
    else if (beat && bytes_q < 7'(LATE_BYTES))
      bytes_d = bytes_q + 1'b1;
    if (done) begin
      wait_d = WAIT_W'(IPG_CYC);
      ncol_d = '0;
    end
    if (col) begin
      hold_d = 1'b1;
      boff_d = '0;
      if (bytes_q >= 7'(LATE_BYTES)) begin
        drop_d = 1'b1;
        ncol_d = '0;
      end else if (ncol_q + 1'b1 >= 5'(MAX_COLL) && !retry_excess) begin
        drop_d = 1'b1;
        ncol_d = '0;
      end else begin
        retry_d = 1'b1;
        if (ncol_q < 5'(MAX_COLL))
          ncol_d = ncol_q + 1'b1;
        boff_d = WAIT_W'(slots) * WAIT_W'(SLOT_CYC);
      end
    end else if (hold_q && !crs) begin
      // the gap after a collision runs from the fall of carrier sense
      hold_d = 1'b0;
      wait_d = WAIT_W'(IPG_CYC) + boff_q;
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= '0;
      boff_q  <= '0;
      ncol_q  <= '0;
      hold_q  <= 1'b0;
      retry_q <= 1'b0;
      drop_q  <= 1'b0;
      bytes_q <= '0;
      lfsr_q  <= 10'h001;
    end else begin
      wait_q  <= wait_d;
      boff_q  <= boff_d;
      ncol_q  <= ncol_d;
      hold_q  <= hold_d;
      retry_q <= retry_d;
      drop_q  <= drop_d;
      bytes_q <= bytes_d;
      lfsr_q  <= lfsr_d;
    end
  end
endmodule

// ### switch_lookup_forwarding_engine.sv
// layer-2 lookup, learning, aging, forwarding and frame buffer engine
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module switch_lookup_forwarding_engine import switch_pkg::*; #(
  parameter int TICK_CYC   = CLK_HZ,
  parameter int DESC_DEPTH = 16
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb register port
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // ingress byte stream from the macs
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_last,
  input  wire logic              rx_err,
  input  wire logic [PORT_W-1:0] rx_port,
  // egress byte stream to the macs
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic      [7:0]        tx_data,
  output logic                   tx_last,
  output logic      [NPORTS-1:0] tx_ports,
  input  wire logic              tx_col,
  input  wire logic              tx_crs
);
  localparam int DW = $clog2(DESC_DEPTH);

  generate
    if (TICK_CYC < 1 || DESC_DEPTH < 2 || (DESC_DEPTH & (DESC_DEPTH - 1)) != 0)
      $error("unsupported parameter value");
  endgenerate

  typedef enum logic [1:0] {I_RX = 2'b00, I_LOOK = 2'b01, I_RES = 2'b11} ist_t;
  typedef enum logic [2:0] {E_IDLE = 3'b000, E_WAIT = 3'b001,
                            E_LOAD = 3'b011, E_SEND = 3'b010,
                            E_COL  = 3'b110} est_t;

  function automatic logic [NPORTS-1:0] port_bit(input logic [PORT_W-1:0] p);
    port_bit = NPORTS'(1) << p;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = a == OFS_GSC1 || a == OFS_MODE || a == OFS_STAT || a == OFS_DROP;
  endfunction

  // frame pool and address table
  logic [7:0] pool [POOL_BYTES];
  entry_t     tbl  [TBL_ENTRIES];
  desc_t      dq   [DESC_DEPTH];

  logic [31:0]       gsc1_q, gsc1_d, mode_q, mode_d, drop_q, drop_d;
  logic [31:0]       prdata_q, prdata_d;
  ist_t              ist_q, ist_d;
  est_t              est_q, est_d;
  logic [PTR_W-1:0]  wr_q, wr_d, fst_q, fst_d, rd_q, rd_d, ep_q, ep_d;
  logic [PTR_W-1:0]  used;
  logic [LEN_W-1:0]  len_q, len_d, len_n, erem_q, erem_d;
  logic              bad_q, bad_d, bad_n, room, pool_we;
  logic [47:0]       da_q, da_d, sa_q, sa_d;
  logic [15:0]       typ_q, typ_d;
  logic [PORT_W-1:0] port_q, port_d, dport_q, dport_d;
  logic [IDX_W-1:0]  idx_q, idx_d, sidx_q, sidx_d, fidx_q, fidx_d;
  logic [IDX_W-1:0]  ag_q, ag_d, tbl_wi;
  logic              shit_q, shit_d, dhit_q, dhit_d, fhit_q, fhit_d;
  logic [IDX_W:0]    cnt_q, cnt_d, clr_q;
  logic [7:0]        sec_q, sec_d;
  logic [31:0]       tick_q, tick_d;
  logic [DW:0]       dh_q, dh_d, dt_q, dt_d;
  logic              tbl_we, push, pop, in_drop, eg_drop, dq_full;
  entry_t            e, tbl_wd;
  desc_t             nd, cur;
  logic [NPORTS-1:0] s1, s2;
  logic [7:0]        txd_q, txd_d;
  logic              tm_go, tm_retry, tm_drop, half, beat, eg_start;

  assign used    = wr_q - rd_q;
  assign room    = used != '1;
  assign dq_full = dh_q == {~dt_q[DW], dt_q[DW-1:0]};
  assign cur     = dq[dh_q[DW-1:0]];
  assign half    = mode_q[MODE_HALF];

  // apb slave: zero wait, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = prdata_q;
  always_comb begin
    gsc1_d   = gsc1_q;
    mode_d   = mode_q;
    drop_d   = drop_q + 32'(in_drop) + 32'(eg_drop);
    prdata_d = prdata_q;
    if (psel && !penable) begin
      unique case (paddr)
        OFS_GSC1: prdata_d = gsc1_q;
        OFS_MODE: prdata_d = mode_q;
        OFS_STAT: prdata_d = {7'h00, 9'(used >> BUF_LSB), 5'h00, cnt_q};
        OFS_DROP: prdata_d = drop_q;
        default:  prdata_d = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite) begin
      if (paddr == OFS_GSC1)
        gsc1_d = pwdata;
      if (paddr == OFS_MODE)
        mode_d = pwdata;
      if (paddr == OFS_DROP)
        drop_d = 32'(in_drop) + 32'(eg_drop); // counted event outlives clear
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gsc1_q   <= GSC1_RST;
      mode_q   <= MODE_RST;
      drop_q   <= '0;
      prdata_q <= '0;
    end else begin
      gsc1_q   <= gsc1_d;
      mode_q   <= mode_d;
      drop_q   <= drop_d;
      prdata_q <= prdata_d;
    end
  end

  // ingress capture, table scan, learning, aging and forwarding decision
  assign rx_ready = ist_q == I_RX;
  always_comb begin
    ist_d = ist_q;  wr_d = wr_q;  fst_d = fst_q;  len_d = len_q;
    bad_d = bad_q;  da_d = da_q;  sa_d = sa_q;    typ_d = typ_q;
    port_d = port_q; idx_d = idx_q; sidx_d = sidx_q; fidx_d = fidx_q;
    dport_d = dport_q; shit_d = shit_q; dhit_d = dhit_q; fhit_d = fhit_q;
    ag_d = ag_q;  cnt_d = cnt_q;  in_drop = 1'b0;
    pool_we = 1'b0; tbl_we = 1'b0; tbl_wi = ag_q; tbl_wd = '0;
    push = 1'b0;  s1 = '0;  s2 = '0;
    len_n = len_q + 1'b1;
    bad_n = bad_q | rx_err | !room | len_q >= LEN_W'(MAX_LEN);
    nd = '{start: fst_q, len: len_q, ports: '0};
    e  = tbl[(ist_q == I_LOOK) ? idx_q : ag_q];
    tick_d = (tick_q == 32'(TICK_CYC - 1)) ? '0 : tick_q + 1'b1;
    sec_d  = (tick_q == 32'(TICK_CYC - 1)) ? sec_q + 1'b1 : sec_q;
    unique case (ist_q)
      I_RX: begin
        // aging walks the table while the lookup port is free
        ag_d = ag_q + 1'b1;
        if (gsc1_q[GSC1_AGE] && e.vld && 8'(sec_q - e.ts) >= 8'(AGE_S)) begin
          tbl_we = 1'b1;
          cnt_d  = cnt_q - 1'b1;
        end
        if (rx_valid) begin
          pool_we = room;
          wr_d    = room ? wr_q + 1'b1 : wr_q;
          len_d   = bad_n ? len_q : len_n;
          bad_d   = bad_n;
          port_d  = rx_port;
          if (len_q < LEN_W'(DA_END))
            da_d = {da_q[39:0], rx_data};
          else if (len_q < LEN_W'(SA_END))
            sa_d = {sa_q[39:0], rx_data};
          else if (len_q < LEN_W'(TYPE_END))
            typ_d = {typ_q[7:0], rx_data};
          if (rx_last) begin
            len_d = '0;
            bad_d = 1'b0;
            if (!bad_n && len_n >= LEN_W'(MIN_LEN)
                && typ_q != PAUSE_TYPE) begin
              ist_d  = I_LOOK;
              len_d  = len_n;
              idx_d  = '0;
              shit_d = 1'b0;
              dhit_d = 1'b0;
              fhit_d = 1'b0;
            end else begin
              wr_d    = fst_q; // frame space is given back
              in_drop = 1'b1;
            end
          end
        end
      end
      I_LOOK: begin
        // full compare over every slot, so no entry is ever shadowed
        if (e.vld && e.mac == sa_q) begin
          shit_d = 1'b1;
          sidx_d = idx_q;
        end
        if (e.vld && e.mac == da_q) begin
          dhit_d  = 1'b1;
          dport_d = e.port;
        end
        if (!e.vld && !fhit_q) begin
          fhit_d = 1'b1;
          fidx_d = idx_q;
        end
        idx_d = idx_q + 1'b1;
        if (idx_q == IDX_W'(TBL_ENTRIES - 1))
          ist_d = I_RES;
      end
      I_RES: begin
        tbl_we = 1'b1;
        tbl_wd = '{vld: 1'b1, mac: sa_q, port: port_q, ts: sec_q};
        if (shit_q)
          tbl_wi = sidx_q;
        else if (fhit_q) begin
          tbl_wi = fidx_q;
          cnt_d  = cnt_q + 1'b1;
        end else
          tbl_wi = IDX_W'(TBL_ENTRIES - 1);
        // stage one from the destination lookup
        if (da_q[40] || !dhit_q)
          s1 = (mode_q[MODE_FILT] && !da_q[40]) ? '0 : '1;
        else
          s1 = port_bit(dport_q);
        // stage two: port enables and no return to the source
        s2 = s1 & mode_q[MODE_FWD +: NPORTS] & ~port_bit(port_q);
        nd.ports = s2;
        ist_d = I_RX;
        len_d = '0;
        if (s2 != '0 && !dq_full)
          push = 1'b1;
        else begin
          wr_d    = fst_q;
          in_drop = 1'b1;
        end
      end
      default: ist_d = I_RX;
    endcase
    if (ist_d == I_RX && ist_q != I_RX)
      fst_d = wr_d;
    if (!clr_q[IDX_W]) begin
      tbl_we = 1'b1;
      tbl_wi = clr_q[IDX_W-1:0];
      tbl_wd = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= I_RX;  wr_q <= '0;  fst_q <= '0;  len_q <= '0;
      bad_q <= 1'b0;  da_q <= '0;  sa_q <= '0;   typ_q <= '0;
      port_q <= '0;   idx_q <= '0; sidx_q <= '0; fidx_q <= '0;
      dport_q <= '0;  shit_q <= 1'b0; dhit_q <= 1'b0; fhit_q <= 1'b0;
      ag_q <= '0;     cnt_q <= '0; sec_q <= '0;  tick_q <= '0;
    end else begin
      ist_q <= ist_d;  wr_q <= wr_d;  fst_q <= fst_d;  len_q <= len_d;
      bad_q <= bad_d;  da_q <= da_d;  sa_q <= sa_d;    typ_q <= typ_d;
      port_q <= port_d; idx_q <= idx_d; sidx_q <= sidx_d; fidx_q <= fidx_d;
      dport_q <= dport_d; shit_q <= shit_d; dhit_q <= dhit_d;
      fhit_q <= fhit_d; ag_q <= ag_d; cnt_q <= cnt_d; sec_q <= sec_d;
      tick_q <= tick_d;
    end
  end

  // storage arrays carry no reset; validity lives in the entry flag
  always_ff @(posedge pclk) begin
    if (pool_we)
      pool[wr_q] <= rx_data;
    if (tbl_we)
      tbl[tbl_wi] <= tbl_wd;
    if (push)
      dq[dt_q[DW-1:0]] <= nd;
  end

  // table flags must start clear, done as a single reset-time sweep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      clr_q <= '0;
    else if (!clr_q[IDX_W])
      clr_q <= clr_q + 1'b1;
  end

  // egress: strict frame order, rewind on collision retry
  assign tx_valid = est_q == E_SEND;
  assign tx_data  = txd_q;
  assign tx_last  = est_q == E_SEND && erem_q == LEN_W'(1);
  assign tx_ports = cur.ports;
  assign beat     = tx_valid && tx_ready && !(half && tx_col);
  assign eg_start = est_q == E_WAIT && tm_go;
  always_comb begin
    est_d = est_q; ep_d = ep_q; erem_d = erem_q; rd_d = rd_q;
    txd_d = txd_q; pop = 1'b0; eg_drop = 1'b0;
    unique case (est_q)
      E_IDLE: if (dh_q != dt_q && clr_q[IDX_W]) begin
        ep_d   = cur.start;
        erem_d = cur.len;
        est_d  = E_WAIT;
      end
      E_WAIT: if (tm_go)
        est_d = E_LOAD;
      E_LOAD: begin
        txd_d = pool[ep_q];
        est_d = E_SEND;
      end
      E_SEND: begin
        if (half && tx_col)
          est_d = E_COL;
        else if (tx_ready) begin
          ep_d   = ep_q + 1'b1;
          erem_d = erem_q - 1'b1;
          txd_d  = pool[ep_d];
          if (erem_q == LEN_W'(1)) begin
            pop   = 1'b1;
            est_d = E_IDLE;
          end
        end
      end
      E_COL: begin
        if (tm_retry) begin
          ep_d   = cur.start;
          erem_d = cur.len;
          est_d  = E_WAIT;
        end else if (tm_drop) begin
          pop     = 1'b1;
          eg_drop = 1'b1;
          est_d   = E_IDLE;
        end
      end
      default: est_d = E_IDLE;
    endcase
    if (pop)
      rd_d = cur.start + PTR_W'(cur.len);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      est_q <= E_IDLE; ep_q <= '0; erem_q <= '0; rd_q <= '0;
      txd_q <= '0; dh_q <= '0; dt_q <= '0;
    end else begin
      est_q <= est_d; ep_q <= ep_d; erem_q <= erem_d; rd_q <= rd_d;
      txd_q <= txd_d;
      dh_q  <= pop ? dh_q + 1'b1 : dh_q;
      dt_q  <= push ? dt_q + 1'b1 : dt_q;
    end
  end

  tx_timing u_tx_timing (
    .clk          (pclk),
    .rst_n        (presetn),
    .half         (half),
    .aggr         (mode_q[MODE_AGGR]),
    .retry_excess (gsc1_q[GSC1_RETRY]),
    .start        (eg_start),
    .beat         (beat),
    .done         (pop && !eg_drop),
    .col          (est_q == E_SEND && half && tx_col),
    .crs          (tx_crs),
    .go           (tm_go),
    .retry        (tm_retry),
    .drop         (tm_drop)
  );
endmodule

// ### switch_engine_props.sv
// port-level assertions for the switch engine
`timescale 1ns/1ps
module switch_engine_props import switch_pkg::*; (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // ingress stream
  input wire logic              rx_valid,
  input wire logic              rx_ready,
  input wire logic              rx_last,
  input wire logic              rx_err,
  // egress stream
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_last,
  input wire logic [NPORTS-1:0] tx_ports,
  input wire logic              tx_crs
);
  logic [7:0]  gap_q, gap_d;
  logic [10:0] len_q, len_d;
  logic        bad_q, bad_d, mapped;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign mapped = paddr inside {OFS_GSC1, OFS_MODE, OFS_STAT, OFS_DROP};
  // cycles since the end of the last egress frame or carrier, saturating
  always_comb begin
    gap_d = gap_q + {7'h00, gap_q != 8'hff};
    if (tx_valid && tx_ready && tx_last || tx_crs)
      gap_d = 8'h00;
    len_d = len_q;
    bad_d = bad_q;
    if (rx_valid && rx_ready) begin
      len_d = rx_last ? 11'h000 : len_q + 11'h001;
      bad_d = !rx_last && (bad_q || rx_err);
    end
  end
  // start saturated so the first frame after reset does not trip the gap check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 8'hff;
      len_q <= 11'h000;
      bad_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      len_q <= len_d;
      bad_q <= bad_d;
    end
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_rx_end;
    rx_valid && rx_ready && rx_last;
  endsequence
  property p_ready;
    s_access |-> pready;
  endproperty
  property p_unmapped;
    s_access ##0 !mapped |-> pslverr && prdata == '0;
  endproperty
  property p_mapped;
    s_access ##0 mapped |-> !pslverr;
  endproperty
  property p_setup;
    psel && !penable |-> !pslverr;
  endproperty
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  property p_ports;
    tx_valid && !(tx_ready && tx_last) |=> $stable(tx_ports);
  endproperty
  property p_gap;
    $rose(tx_valid) |-> gap_q >= 8'(IPG_CYC - 1);
  endproperty
  // an errored, short or long frame never stalls the ingress
  property p_bad;
    s_rx_end ##0 (bad_q || rx_err || len_q < 11'h03f || len_q > 11'h5ff)
      |=> rx_ready;
  endproperty
  property p_last;
    tx_last |-> tx_valid;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  a_mapped: assert property (p_mapped) else $error("spurious slave error");
  a_setup: assert property (p_setup) else $error("error in setup");
  a_hold: assert property (p_hold) else $error("egress byte not held");
  a_ports: assert property (p_ports) else $error("port set moved");
  a_gap: assert property (p_gap) else $error("gap too short");
  a_bad: assert property (p_bad) else $error("bad frame stalled");
  a_last: assert property (p_last) else $error("last without valid");
endmodule

bind switch_lookup_forwarding_engine switch_engine_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_last(rx_last),
  .rx_err(rx_err), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .tx_last(tx_last), .tx_ports(tx_ports),
  .tx_crs(tx_crs)
);

// ### egress_mac_model.sv
// egress mac sink: accepts bytes, optionally stalling, and logs frames
`timescale 1ns/1ps
module egress_mac_model import switch_pkg::*; (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // egress stream
  input  wire logic              tx_valid,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_last,
  input  wire logic [NPORTS-1:0] tx_ports,
  output logic                   tx_ready,
  // control and log
  input  wire logic              slow,
  output logic      [15:0]       frames,
  output logic      [15:0]       last_len,
  output logic      [NPORTS-1:0] last_ports,
  output logic      [7:0]        first_byte
);
  logic [15:0] cnt_q;
  logic        tog_q;
  // slow mode takes every other cycle so the engine must hold its byte
  assign tx_ready = !slow || tog_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q      <= 1'b0;
      cnt_q      <= '0;
      frames     <= '0;
      last_len   <= '0;
      last_ports <= '0;
      first_byte <= '0;
    end else begin
      tog_q <= !tog_q;
      if (tx_valid && tx_ready) begin
        cnt_q <= tx_last ? 16'h0000 : cnt_q + 16'h0001;
        if (cnt_q == 16'h0000)
          first_byte <= tx_data;
        if (tx_last) begin
          frames     <= frames + 16'h0001;
          last_len   <= cnt_q + 16'h0001;
          last_ports <= tx_ports;
        end
      end
    end
  end
endmodule

// ### switch_lookup_forwarding_engine_bench.sv
// self-checking bench for the switch lookup and forwarding engine
`timescale 1ns/1ps
module switch_lookup_forwarding_engine_bench import switch_pkg::*; ;
  localparam logic [47:0] MA = 48'h0200_0000_00a1;
  localparam logic [47:0] MB = 48'h0200_0000_00b2;
  localparam logic [47:0] MC = 48'h0200_0000_00c3;
  localparam logic [47:0] MD = 48'h0200_0000_00d4;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic              pwrite = 0, rx_valid = 0, rx_last = 0, rx_err = 0;
  logic              tx_col = 0, tx_crs = 0, slow = 0;
  logic              pready, pslverr, rx_ready, tx_valid, tx_ready, tx_last;
  logic [11:0]       paddr = '0;
  logic [31:0]       pwdata = '0, prdata;
  logic [7:0]        rx_data = '0, tx_data, first_byte;
  logic [PORT_W-1:0] rx_port = '0;
  logic [NPORTS-1:0] tx_ports, last_ports;
  logic [15:0]       frames, last_len;
  int                fail_count, tests_run, cyc, nf, nd, nt;
  always #50 pclk = ~pclk;
  switch_lookup_forwarding_engine #(.TICK_CYC(50), .DESC_DEPTH(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
    .rx_err(rx_err), .rx_port(rx_port), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ports(tx_ports), .tx_col(tx_col), .tx_crs(tx_crs));
  egress_mac_model mac (
    .pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ports(tx_ports),
    .tx_ready(tx_ready), .slow(slow), .frames(frames),
    .last_len(last_len), .last_ports(last_ports), .first_byte(first_byte));
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rreg(input logic [11:0] a, input logic [31:0] m, x);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, '0, rd, er);
    chk(rd & m, x);
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask
  // send one frame, let it drain, then judge egress and drop count
  task automatic frame(input logic [PORT_W-1:0] p, input logic [47:0] d, s,
                       input logic [15:0] ty, input int n, input logic e,
                       input logic [NPORTS-1:0] xp);
    logic [111:0] h;
    h = {d, s, ty};
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_port <= p;
      rx_data <= (i < 14) ? h[111-8*i -: 8] : i[7:0];
      rx_last <= (i == n - 1);
      rx_err <= e;
      @(posedge pclk);
      while (rx_ready !== 1'b1) @(posedge pclk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_err <= 1'b0;
    repeat (1500) @(posedge pclk);
    if (xp == '0) nd++;
    else nf++;
    chk(32'(frames), 32'(nf));
    rreg(OFS_DROP, '1, 32'(nd));
    if (xp != '0) begin
      chk(32'(last_ports), 32'(xp));
      chk(32'(last_len), 32'(n));
      chk(32'(first_byte), 32'(d[47:40]));
    end
  endtask
  task automatic t_regs();
    logic [31:0] rd;
    logic        er;
    rreg(OFS_GSC1, '1, GSC1_RST);
    rreg(OFS_MODE, '1, MODE_RST);
    wreg(OFS_GSC1, 32'h0000_0500);
    rreg(OFS_GSC1, '1, 32'h0000_0500);
    wreg(OFS_GSC1, GSC1_RST);
    apb(1'b0, 12'h010, '0, rd, er);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, '0);
  endtask
  task automatic t_learn();
    frame(1, MB, MA, 16'h0800, 64, 0, 3'b101);
    rreg(OFS_STAT, 32'h0000_07ff, 32'h0000_0001);
    frame(2, MA, MB, 16'h0800, 64, 0, 3'b010);
    frame(2, 48'h0200_0000_00a0, MB, 16'h0800, 64, 0, 3'b011);
    rreg(OFS_STAT, 32'h0000_07ff, 32'h0000_0002);
  endtask
  task automatic t_drop();
    frame(1, MA, MA, 16'h0800, 64, 0, 3'b000);
    frame(0, MB, MC, 16'h0800, 64, 1, 3'b000);
    frame(0, MB, MC, 16'h0800, 63, 0, 3'b000);
    frame(1, MB, MA, PAUSE_TYPE, 64, 0, 3'b000);
    rreg(OFS_STAT, 32'h0000_07ff, 32'h0000_0002);
  endtask
  // egress stalls here so held bytes are exercised
  task automatic t_migrate();
    slow <= 1'b1;
    frame(0, MB, MA, 16'h0800, 130, 0, 3'b100);
    frame(2, MA, MB, 16'h0800, 64, 0, 3'b001);
    slow <= 1'b0;
    rreg(OFS_STAT, 32'h0000_07ff, 32'h0000_0002);
  endtask
  task automatic t_filter();
    wreg(OFS_MODE, 32'h0000_0701);
    frame(0, MD, MA, 16'h0800, 64, 0, 3'b000);
    wreg(OFS_MODE, MODE_RST);
    frame(0, MD, MA, 16'h0800, 64, 0, 3'b110);
    wreg(OFS_DROP, '0);
    nd = 0;
    rreg(OFS_DROP, '1, '0);
  endtask
  task automatic t_aging();
    repeat (12000) @(posedge pclk);
    rreg(OFS_STAT, 32'h01ff_07ff, '0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    repeat (2100) @(posedge pclk);
    t_learn();
    t_drop();
    t_migrate();
    t_filter();
    t_aging();
    results();
  end
endmodule
